// *** instr_exec_consts.svh ***
`ifndef INSTR_EXEC_CONSTS_SVH
`define INSTR_EXEC_CONSTS_SVH

// Opcode match patterns on the upper byte of the program word
`define OPC_TEST_SKIP_MASK 8'hF8
`define OPC_TEST_SKIP_VAL 8'h90
`define OPC_TOGGLE_MASK 8'hF8
`define OPC_TOGGLE_VAL 8'h38
`define OPC_BANK_HIGH_MASK 8'hFE
`define OPC_BANK_HIGH_VAL 8'hBA
`define OPC_LIT_WORKING_ACCUMULATOR_MASK 8'hFF
`define OPC_LIT_WORKING_ACCUMULATOR_VAL 8'hB0

// Field positions inside the program word
`define FLD_OPC_HI 15
`define FLD_OPC_LO 8
`define FLD_BIT_HI 10
`define FLD_BIT_LO 8
`define FLD_ADDR_HI 7
`define FLD_ADDR_LO 0
`define FLD_NIB_HI 7
`define FLD_NIB_LO 4

// Bank select high and low nibble positions and reset values
`define BANK_HI_HI 7
`define BANK_HI_LO 4
`define BANK_LO_HI 3
`define BANK_LO_LO 0
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

`endif

// *** instr_exec_pkg.sv ***
package instr_exec_pkg;

    // Quarter phases of one instruction cycle
    typedef enum logic [3:0] {
        PH_DECODE = 4'h1,
        PH_READ = 4'h2,
        PH_EXEC = 4'h4,
        PH_WRITE = 4'h8
    } phase_t;

    // Decoded instruction class
    typedef enum logic [4:0] {
        OP_NONE = 5'h01,
        OP_TEST_SKIP = 5'h02,
        OP_TOGGLE = 5'h04,
        OP_BANK_HIGH = 5'h08,
        OP_LIT_WORKING_ACCUMULATOR = 5'h10
    } op_t;

endpackage

// *** regfile_if.sv ***
`timescale 1ns/100ps
`default_nettype none

// Phase and cycle-end signals between the executer and its phase sequencer
interface regfile_if;
    instr_exec_pkg::phase_t phase;
    logic cycle_end;

    modport seq (output phase, output cycle_end);
    modport core (input phase, input cycle_end);
endinterface

`default_nettype wire

// *** quarter_phase_seq.sv ***
`timescale 1ns/100ps
`default_nettype none

// Steps the four quarter phases, one per rising clk edge
module quarter_phase_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Phase outputs
    regfile_if.seq ph
);
    instr_exec_pkg::phase_t phase_reg;

    // One-hot ring; advances on every rising edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= instr_exec_pkg::PH_DECODE;
        end else begin
            case (phase_reg)
                instr_exec_pkg::PH_DECODE: phase_reg <= instr_exec_pkg::PH_READ;
                instr_exec_pkg::PH_READ: phase_reg <= instr_exec_pkg::PH_EXEC;
                instr_exec_pkg::PH_EXEC: phase_reg <= instr_exec_pkg::PH_WRITE;
                instr_exec_pkg::PH_WRITE: phase_reg <= instr_exec_pkg::PH_DECODE;
                default: phase_reg <= instr_exec_pkg::PH_DECODE;
            endcase
        end
    end

    assign ph.phase = phase_reg;
    assign ph.cycle_end = (phase_reg == instr_exec_pkg::PH_WRITE);
endmodule // quarter_phase_seq

`default_nettype wire

// *** bit_and_literal_instr_exec.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "instr_exec_consts.svh"

module bit_and_literal_instr_exec #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8,
    parameter bit BASE_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Program memory side
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    output logic instr_taken,
    // Register file port
    output logic [ADDR_W-1:0] rf_addr,
    input wire logic [DATA_W-1:0] rf_rdata,
    output logic [DATA_W-1:0] rf_wdata,
    output logic rf_we,
    // Architectural state
    output logic [DATA_W-1:0] working_accumulator,
    output logic [DATA_W-1:0] bank_select_register,
    // Status
    output logic skip_active,
    output logic status_flags_we,
    output logic illegal_op
);
    // Widths are tied to the encoding; refuse anything the field slices cannot feed
    if (ADDR_W != (`FLD_ADDR_HI - `FLD_ADDR_LO + 1)
            || DATA_W != (`BANK_HI_HI - `BANK_LO_LO + 1)) begin : g_width_check
        $error("bit_and_literal_instr_exec supports only 8-bit address and data");
    end

    // Quarter phase sequencer; every stage below keys off its one-hot phase
    regfile_if ph_bus ();
    quarter_phase_seq u_seq (
        .clk(clk),
        .nrst(nrst),
        .ph(ph_bus.seq)
    );

    // Latched instruction and its decoded class
    instr_exec_pkg::op_t op_reg;
    instr_exec_pkg::op_t op_next;
    logic [15:0] ir_reg;
    logic illegal_reg;

    // Per-stage data and architectural state
    logic [DATA_W-1:0] operand_reg;
    logic [DATA_W-1:0] working_accumulator_reg;
    logic [DATA_W-1:0] bsr_reg;
    logic skip_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic we_reg;

    // Per-phase strobes, exactly one of them high in every quarter
    logic in_decode;
    logic in_read;
    logic in_exec;
    logic in_write;

    // Upper byte of the fetched word and its per-class matches
    logic [7:0] opc_hi;
    logic hit_test_skip;
    logic hit_toggle;
    logic hit_bank_high;
    logic hit_lit_working_accumulator;

    // Decode helper used for every opcode class
    function automatic logic opc_match(input logic [7:0] hi, input logic [7:0] mask,
                                       input logic [7:0] val);
        opc_match = ((hi & mask) == val);
    endfunction

    // Phase test; kept in one place so every stage agrees on the phase order
    function automatic logic at_phase(input instr_exec_pkg::phase_t now,
                                      input instr_exec_pkg::phase_t want);
        at_phase = (now == want);
    endfunction

    // Bit index field, shared by the test and the toggle paths
    function automatic logic [`FLD_BIT_HI-`FLD_BIT_LO:0] bit_index(input logic [15:0] word);
        bit_index = word[`FLD_BIT_HI:`FLD_BIT_LO];
    endfunction

    // One-hot mask of the indexed bit; both paths use it so they agree on bit order
    function automatic logic [DATA_W-1:0] bit_mask(
            input logic [`FLD_BIT_HI-`FLD_BIT_LO:0] idx);
        bit_mask = DATA_W'(1) << idx;
    endfunction

    // Phase strobes from the sequencer
    assign in_decode = at_phase(ph_bus.phase, instr_exec_pkg::PH_DECODE);
    assign in_read = at_phase(ph_bus.phase, instr_exec_pkg::PH_READ);
    assign in_exec = at_phase(ph_bus.phase, instr_exec_pkg::PH_EXEC);
    assign in_write = at_phase(ph_bus.phase, instr_exec_pkg::PH_WRITE);

    // Opcode class matches on the upper byte of the fetched word
    assign opc_hi = instr_word[`FLD_OPC_HI:`FLD_OPC_LO];
    assign hit_test_skip = opc_match(opc_hi, `OPC_TEST_SKIP_MASK,
                                     `OPC_TEST_SKIP_VAL);
    assign hit_toggle = opc_match(opc_hi, `OPC_TOGGLE_MASK,
                                  `OPC_TOGGLE_VAL);
    assign hit_lit_working_accumulator = opc_match(opc_hi, `OPC_LIT_WORKING_ACCUMULATOR_MASK,
                                    `OPC_LIT_WORKING_ACCUMULATOR_VAL);

    // Base variant never sees bank-high as an opcode, so it falls to a flagged no-op
    assign hit_bank_high = opc_match(opc_hi, `OPC_BANK_HIGH_MASK, `OPC_BANK_HIGH_VAL)
                           && !BASE_VARIANT;

    // Classify the fetched word; the masks never overlap, so the order is only a tie-break
    always_comb begin
        op_next = instr_exec_pkg::OP_NONE;
        if (hit_test_skip) begin
            op_next = instr_exec_pkg::OP_TEST_SKIP;
        end else if (hit_toggle) begin
            op_next = instr_exec_pkg::OP_TOGGLE;
        end else if (hit_bank_high) begin
            op_next = instr_exec_pkg::OP_BANK_HIGH;
        end else if (hit_lit_working_accumulator) begin
            op_next = instr_exec_pkg::OP_LIT_WORKING_ACCUMULATOR;
        end
    end

    // Stage registers. Each concern has its own process and acts in one quarter only, except that we_reg is also cleared in the other three,
    // so an operand read in one quarter is never overwritten before it is used.
    // Limitation: the register file must answer within the read quarter; this port
    // has no wait state.

    // Decode phase latches the word; a pending skip forces a no-op instead
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            op_reg <= instr_exec_pkg::OP_NONE;
            ir_reg <= `RST_WORD;
            illegal_reg <= 1'b0;
        end else if (in_decode) begin
            if (skip_reg || !instr_valid) begin
                op_reg <= instr_exec_pkg::OP_NONE;
                ir_reg <= `RST_WORD;
                illegal_reg <= 1'b0;
            end else begin
                op_reg <= op_next;
                ir_reg <= instr_word;
                illegal_reg <= (op_next == instr_exec_pkg::OP_NONE);
            end
        end
    end

    // Read phase captures the addressed register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            operand_reg <= `RST_BYTE;
        end else if (in_read) begin
            operand_reg <= rf_rdata;
        end
    end

    // Skip flag: set by a true test in execute, cleared in the execute quarter of the forced no-op
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            skip_reg <= 1'b0;
        end else if (in_exec) begin
            if (op_reg == instr_exec_pkg::OP_TEST_SKIP) begin
                skip_reg <= |(operand_reg & bit_mask(bit_index(ir_reg)));
            end else begin
                skip_reg <= 1'b0;
            end
        end
    end

    // Execute phase forms the toggled byte for the write-back
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wdata_reg <= `RST_BYTE;
            we_reg <= 1'b0;
        end else if (in_exec) begin
            wdata_reg <= operand_reg ^ bit_mask(bit_index(ir_reg));
            we_reg <= (op_reg == instr_exec_pkg::OP_TOGGLE);
        end else begin
            we_reg <= 1'b0;
        end
    end

    // Write phase updates the working register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            working_accumulator_reg <= `RST_BYTE;
        end else if (in_write && op_reg == instr_exec_pkg::OP_LIT_WORKING_ACCUMULATOR) begin
            working_accumulator_reg <= DATA_W'(ir_reg[`FLD_ADDR_HI:`FLD_ADDR_LO]);
        end
    end

    // Write phase updates only the upper nibble of bank select
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bsr_reg <= `RST_BYTE;
        end else if (in_write && op_reg == instr_exec_pkg::OP_BANK_HIGH) begin
            bsr_reg[`BANK_HI_HI:`BANK_HI_LO] <= ir_reg[`FLD_NIB_HI:`FLD_NIB_LO];
            bsr_reg[`BANK_LO_HI:`BANK_LO_LO] <= bsr_reg[`BANK_LO_HI:`BANK_LO_LO];
        end
    end

    // Register file port; the address comes straight from the latched word
    assign rf_addr = ADDR_W'(ir_reg[`FLD_ADDR_HI:`FLD_ADDR_LO]);
    assign rf_wdata = wdata_reg;
    assign rf_we = we_reg;

    // Architectural state
    assign working_accumulator = working_accumulator_reg;
    assign bank_select_register = bsr_reg;

    // Status; the flag write enable stays low since none of these ops touch status
    assign skip_active = skip_reg;
    assign status_flags_we = 1'b0;
    assign illegal_op = illegal_reg;

    // Fetch handshake; a valid word is taken on every decode edge, even one a skip kills
    assign instr_taken = in_decode && instr_valid;
endmodule // bit_and_literal_instr_exec

`default_nettype wire

// *** instr_exec_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
// Phase is rebuilt from reset, the way the core counts it
module instr_exec_chk #(parameter bit BASE_VARIANT = 1'b0) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Program side
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic instr_taken,
    // Register file
    input wire logic [7:0] rf_addr,
    input wire logic [7:0] rf_rdata,
    input wire logic [7:0] rf_wdata,
    input wire logic rf_we,
    // State and status
    input wire logic [7:0] working_accumulator,
    input wire logic [7:0] bank_select_register,
    input wire logic skip_active,
    input wire logic status_flags_we,
    input wire logic illegal_op
);
    logic [1:0] ph_reg;
    logic [15:0] ir_reg;
    logic [7:0] rd_reg;
    logic live_reg;
    logic tst, tgl, bnk, lit;
    // First edge after reset is a decode edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph_reg <= 2'h0;
        end else begin
            ph_reg <= ph_reg + 2'h1;
        end
    end
    // A word fetched under a skip is dead
    always_ff @(posedge clk) begin
        if (ph_reg == 2'h0) begin
            ir_reg <= instr_word;
            live_reg <= instr_valid & ~skip_active;
        end
        if (ph_reg == 2'h1) begin
            rd_reg <= rf_rdata;
        end
    end
    // Decoded classes of the live word
    assign tst = live_reg && ir_reg[15:11] == 5'h12;
    assign tgl = live_reg && ir_reg[15:11] == 5'h07;
    assign bnk = live_reg && ir_reg[15:9] == 7'h5D && !BASE_VARIANT;
    assign lit = live_reg && ir_reg[15:8] == 8'hB0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_we; rf_we |-> ph_reg == 2'h3 && tgl; endproperty
    a_we: assert property (p_we) else $error("stray write");
    property p_tgl;
        ph_reg == 2'h3 && tgl |-> rf_we && rf_wdata == (rd_reg ^ (8'h01 << ir_reg[10:8]));
    endproperty
    a_tgl: assert property (p_tgl) else $error("toggle");
    property p_skip; ph_reg == 2'h2 && tst |=> skip_active == rd_reg[ir_reg[10:8]]; endproperty
    a_skip: assert property (p_skip) else $error("skip");
    property p_noskip; ph_reg == 2'h2 && !tst |=> !skip_active; endproperty
    a_noskip: assert property (p_noskip) else $error("long skip");
    property p_lit; ph_reg == 2'h3 && lit |=> working_accumulator == ir_reg[7:0]; endproperty
    a_lit: assert property (p_lit) else $error("literal");
    property p_bank;
        ph_reg == 2'h3 && bnk |=>
            bank_select_register == {ir_reg[7:4], $past(bank_select_register[3:0])};
    endproperty
    a_bank: assert property (p_bank) else $error("bank");
    property p_bhold; ph_reg == 2'h3 && !bnk |=> $stable(bank_select_register); endproperty
    a_bhold: assert property (p_bhold) else $error("bank hold");
    property p_flg; !status_flags_we; endproperty
    a_flg: assert property (p_flg) else $error("flags");
    // Main scenarios
    cover property (ph_reg == 2'h2 && tst ##1 skip_active);
    cover property (rf_we);
    cover property (ph_reg == 2'h3 && bnk);
endmodule // instr_exec_chk
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // Stimulus and expectations
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic instr_valid = 1'b0;
    logic [7:0] rf_rdata = 8'h00;
    logic [7:0] acc_exp = 8'h00;
    logic [7:0] bsr_exp = 8'h00;
    logic instr_taken, rf_we, skip_active, status_flags_we, illegal_op;
    logic [7:0] rf_addr, rf_wdata, working_accumulator, bank_select_register;
    logic [7:0] base_bsr;
    logic base_ill;
    int err_total = 0;
    int num_checks = 0;
    always #25 clk = ~clk;
    bit_and_literal_instr_exec dut (.clk, .nrst, .instr_word, .instr_valid, .instr_taken,
        .rf_addr, .rf_rdata, .rf_wdata, .rf_we, .working_accumulator,
        .bank_select_register, .skip_active, .status_flags_we, .illegal_op);
    // Base variant copy fed the same words; it must refuse bank-high loads
    bit_and_literal_instr_exec #(.BASE_VARIANT(1'b1)) dut_base (.clk, .nrst, .instr_word,
        .instr_valid, .instr_taken(), .rf_addr(), .rf_rdata, .rf_wdata(), .rf_we(),
        .working_accumulator(), .bank_select_register(base_bsr), .skip_active(),
        .status_flags_we(), .illegal_op(base_ill));
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One word per four edges; prior results judged first, as they land on the write edge.
    // ex holds {base variant illegal, illegal, word executes, write strobe, skip}
    task automatic step(input logic [15:0] w, input logic [7:0] rd, input logic v,
            input logic [4:0] ex, input logic [7:0] wd);
        instr_word <= w;
        instr_valid <= v;
        rf_rdata <= rd;
        @(negedge clk);
        check(working_accumulator, acc_exp);
        check(bank_select_register, bsr_exp);
        check(base_bsr, 8'h00);
        check({7'h00, instr_taken}, {7'h00, v});
        repeat (3) @(posedge clk);
        @(negedge clk);
        check({6'h00, rf_we, skip_active}, {6'h00, ex[1:0]});
        check({6'h00, illegal_op, base_ill}, {6'h00, ex[3], ex[4]});
        check(rf_addr, ex[2] ? w[7:0] : 8'h00);
        if (ex[1]) begin
            check(rf_wdata, wd);
        end
        @(posedge clk);
    endtask
    // Literal loads; a word without valid changes nothing
    task automatic lit_loads();
        step(16'hB05A, 8'h00, 1'b1, 5'b00100, 8'h00);
        acc_exp = 8'h5A;
        step(16'hB0A5, 8'h00, 1'b1, 5'b00100, 8'h00);
        acc_exp = 8'hA5;
        step(16'hB03C, 8'h00, 1'b0, 5'b00000, 8'h00);
    endtask
    // Bank high loads, spare bits zero as code generators emit them; base variant refuses
    task automatic bank_loads();
        step(16'hBA50, 8'h00, 1'b1, 5'b10100, 8'h00);
        bsr_exp = 8'h50;
        step(16'hBAF0, 8'hFF, 1'b1, 5'b10100, 8'h00);
        bsr_exp = 8'hF0;
        step(16'hB03C, 8'h00, 1'b0, 5'b00000, 8'h00);
    endtask
    // Toggle every bit index, back to back
    task automatic toggles();
        for (int b = 0; b < 8; b++) begin
            step({5'h07, b[2:0], 8'h3C}, 8'hA5, 1'b1, 5'b00110, 8'hA5 ^ (8'h01 << b));
        end
    endtask
    // A taken skip kills the next load; a clear bit lets it through
    task automatic skips();
        step({5'h12, 3'h6, 8'h20}, 8'h40, 1'b1, 5'b00101, 8'h00);
        step(16'hB0EE, 8'h00, 1'b1, 5'b00000, 8'h00);
        step({5'h12, 3'h6, 8'h20}, 8'hBF, 1'b1, 5'b00100, 8'h00);
        step(16'hB0EE, 8'h00, 1'b1, 5'b00100, 8'h00);
        acc_exp = 8'hEE;
        step(16'hB03C, 8'h00, 1'b0, 5'b00000, 8'h00);
    endtask
    // A word of no known class runs as a flagged no-op and changes no state
    task automatic bad_words();
        step(16'h0042, 8'h00, 1'b1, 5'b11100, 8'h00);
        step(16'hB03C, 8'h00, 1'b0, 5'b00000, 8'h00);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        lit_loads();
        bank_loads();
        toggles();
        skips();
        bad_words();
        results();
    end
endmodule // testbench
bind bit_and_literal_instr_exec instr_exec_chk #(.BASE_VARIANT(BASE_VARIANT)) chk (.clk, .nrst,
    .instr_word, .instr_valid, .instr_taken, .rf_addr, .rf_rdata, .rf_wdata, .rf_we,
    .working_accumulator, .bank_select_register, .skip_active, .status_flags_we, .illegal_op);
`default_nettype wire
